// *** hdl/irp_pkg.sv ***
// Constants shared by the input reference priority register bank.
package irp_pkg;
    localparam logic [6:0] IRP_OFS_PRIO_9_10   = 7'h1c;
    localparam logic [6:0] IRP_OFS_PRIO_11_12  = 7'h1d;
    localparam int         IRP_ODD_LSB         = 0;
    localparam int         IRP_EVEN_LSB        = 4;
    localparam logic [7:0] IRP_RST_9_10_MAIN   = 8'hba;
    localparam logic [7:0] IRP_RST_9_10_AUX    = 8'hba;
    localparam logic [7:0] IRP_RST_11_12_MAIN  = 8'hdc;
    localparam logic [7:0] IRP_RST_11_12_AUX   = 8'h00;
    localparam logic [3:0] IRP_PRIO_11_MASTER  = 4'hc;
    localparam logic [3:0] IRP_PRIO_11_SLAVE   = 4'h1;
    localparam logic [3:0] IRP_PRIO_OFF        = 4'h0;
    localparam logic [3:0] IRP_NO_INPUT        = 4'h0;
    localparam logic [7:0] IRP_READ_UNMAPPED   = 8'h00;
endpackage

// *** hdl/irp_input_priority_regs.sv ***
// Priority registers for reference inputs 9 to 12, main and auxiliary path copies.
// Contract
// - Two priorities per register: odd input low nibble, even input high nibble.
// - Smaller nonzero priority value ranks higher in automatic selection.
// - Priority zero removes that input from automatic selection.
// - Bank select 0 reaches main path copy, 1 reaches auxiliary copy.
// - Inputs 9/10 register resets to 1011 1010 in both copies.
// - Inputs 11/12 resets to 1101 1100 main with master strap (1101 0001 with slave), zero auxiliary.
// - Strap sampled at each reset: master gives input 11 priority 12, slave 1.
`timescale 1ns/100ps
`default_nettype none

module irp_input_priority_regs (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    // Strap and bank select from the neighbouring control register.
    input  wire logic       master_slave_strap_i,
    input  wire logic       path_bank_select_i,
    // Microprocessor port.
    input  wire logic [6:0] cpu_addr_i,
    input  wire logic       cpu_wr_i,
    input  wire logic       cpu_rd_i,
    input  wire logic [7:0] cpu_wdata_i,
    output logic      [7:0] cpu_rdata_o,
    output logic            cpu_rvalid_o,
    // Ranked result per path: winning input number 9..12, 0 when none enabled.
    output logic      [3:0] main_best_input_o,
    output logic      [3:0] aux_best_input_o,
    // Stored priorities of the main path, for the source selector.
    output logic      [7:0] main_prio_9_10_o,
    output logic      [7:0] main_prio_11_12_o
);

    // Cuts one 4-bit priority field out of a register byte.
    // Odd numbered inputs sit in the low nibble and even numbered inputs in the high nibble.
    function automatic logic [3:0] prio_field(input logic [7:0] r, input logic odd);
        logic [3:0] f;
        if (odd) begin
            f = r[irp_pkg::IRP_ODD_LSB +: 4];
        end else begin
            f = r[irp_pkg::IRP_EVEN_LSB +: 4];
        end
        return f;
    endfunction

    // True when a field takes part in the ranking; the all-zero code parks its input.
    function automatic logic prio_enabled(input logic [3:0] p);
        return p != irp_pkg::IRP_PRIO_OFF;
    endfunction

    // True when a field outranks the best candidate found so far.
    // Only a strictly smaller value wins, so on equal values the lower numbered input stays.
    function automatic logic prio_beats(input logic [3:0] p, input logic [3:0] best_p, input logic have_best);
        return prio_enabled(p) && (!have_best || p < best_p);
    endfunction

    // Picks the input with the smallest enabled priority; the result is 0 when every input is parked.
    // The loop unrolls into a chain of four compares, short enough for one cycle at this clock rate.
    function automatic logic [3:0] best_input(input logic [7:0] r910, input logic [7:0] r1112);
        logic [3:0] p [4];
        logic [3:0] best_p;
        logic [3:0] best_n;
        p[0] = prio_field(r910, 1'h1);
        p[1] = prio_field(r910, 1'h0);
        p[2] = prio_field(r1112, 1'h1);
        p[3] = prio_field(r1112, 1'h0);
        best_p = 4'hf;
        best_n = irp_pkg::IRP_NO_INPUT;
        for (int i = 0; i < 4; i++) begin
            if (prio_beats(p[i], best_p, best_n != irp_pkg::IRP_NO_INPUT)) begin
                best_p = p[i];
                best_n = 4'(9 + i);
            end
        end
        return best_n;
    endfunction

    // Matches the port address against one register offset; used for every byte of the bank.
    function automatic logic addr_hit(input logic [6:0] addr, input logic [6:0] ofs);
        return addr == ofs;
    endfunction

    // Stored priorities of the main path, with their next values.
    logic [7:0] main_9_10_q;
    logic [7:0] main_9_10_d;
    logic [7:0] main_11_12_q;
    logic [7:0] main_11_12_d;

    // Stored priorities of the auxiliary path, with their next values.
    logic [7:0] aux_9_10_q;
    logic [7:0] aux_9_10_d;
    logic [7:0] aux_11_12_q;
    logic [7:0] aux_11_12_d;

    // Read answer, with its valid pulse.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;

    // Ranking results for the source selector.
    logic [3:0] main_best_q;
    logic [3:0] main_best_d;
    logic [3:0] aux_best_q;
    logic [3:0] aux_best_d;

    // Address decode. An offset outside the bank hits nothing, so a write there is dropped.
    wire logic       hit_9_10  = addr_hit(cpu_addr_i, irp_pkg::IRP_OFS_PRIO_9_10);
    wire logic       hit_11_12 = addr_hit(cpu_addr_i, irp_pkg::IRP_OFS_PRIO_11_12);

    // Bank steering. The select is a level taken in the cycle of the strobe, so software must
    // settle it before the access; a change in the same cycle as the strobe is not filtered.
    wire logic       wr_main   = cpu_wr_i && !path_bank_select_i;
    wire logic       wr_aux    = cpu_wr_i && path_bank_select_i;

    // One write enable per stored byte; at most one of them is high in any cycle.
    wire logic       we_main_9_10  = wr_main && hit_9_10;
    wire logic       we_main_11_12 = wr_main && hit_11_12;
    wire logic       we_aux_9_10   = wr_aux && hit_9_10;
    wire logic       we_aux_11_12  = wr_aux && hit_11_12;

    // A write replaces the whole byte, so both nibbles of a register change together.
    assign main_9_10_d  = we_main_9_10 ? cpu_wdata_i : main_9_10_q;
    assign main_11_12_d = we_main_11_12 ? cpu_wdata_i : main_11_12_q;
    assign aux_9_10_d   = we_aux_9_10 ? cpu_wdata_i : aux_9_10_q;
    assign aux_11_12_d  = we_aux_11_12 ? cpu_wdata_i : aux_11_12_q;

    // Reset load of the main 11/12 byte. The reset is synchronous, so the strap is caught by the
    // same clocked load; it must be steady while reset is held, and each reset samples it again.
    wire logic [3:0] strap_prio     = master_slave_strap_i ? irp_pkg::IRP_PRIO_11_MASTER
                                                           : irp_pkg::IRP_PRIO_11_SLAVE;
    wire logic [7:0] rst_main_11_12 = {irp_pkg::IRP_RST_11_12_MAIN[7:4], strap_prio};

    // Read selection: the bank select picks the copy, the address picks the byte.
    wire logic [7:0] sel_9_10  = path_bank_select_i ? aux_9_10_q : main_9_10_q;
    wire logic [7:0] sel_11_12 = path_bank_select_i ? aux_11_12_q : main_11_12_q;
    wire logic [7:0] read_mux  = hit_9_10  ? sel_9_10  :
                                 hit_11_12 ? sel_11_12 : irp_pkg::IRP_READ_UNMAPPED;

    // Read data holds its last value between reads; the valid flag marks the fresh one.
    assign rdata_d  = cpu_rd_i ? read_mux : rdata_q;
    assign rvalid_d = cpu_rd_i;

    // Ranking works from the stored bytes, so it lags a write by one cycle.
    // The selector downstream tolerates that latency; it never sees a half written byte.
    assign main_best_d = best_input(main_9_10_q, main_11_12_q);
    assign aux_best_d  = best_input(aux_9_10_q, aux_11_12_q);

    // Main path byte for inputs 9/10.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            main_9_10_q <= irp_pkg::IRP_RST_9_10_MAIN;
        end else begin
            main_9_10_q <= main_9_10_d;
        end
    end

    // Main path byte for inputs 11/12; its reset value carries the strap.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            main_11_12_q <= rst_main_11_12;
        end else begin
            main_11_12_q <= main_11_12_d;
        end
    end

    // Auxiliary path byte for inputs 9/10, kept apart so a main write never disturbs it.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aux_9_10_q <= irp_pkg::IRP_RST_9_10_AUX;
        end else begin
            aux_9_10_q <= aux_9_10_d;
        end
    end

    // Auxiliary path byte for inputs 11/12; it starts with both inputs parked.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aux_11_12_q <= irp_pkg::IRP_RST_11_12_AUX;
        end else begin
            aux_11_12_q <= aux_11_12_d;
        end
    end

    // Registered read answer, one cycle after the strobe.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_q  <= irp_pkg::IRP_READ_UNMAPPED;
            rvalid_q <= 1'h0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Main path ranking result.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            main_best_q <= irp_pkg::IRP_NO_INPUT;
        end else begin
            main_best_q <= main_best_d;
        end
    end

    // Auxiliary path ranking result.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aux_best_q <= irp_pkg::IRP_NO_INPUT;
        end else begin
            aux_best_q <= aux_best_d;
        end
    end

    // Outputs come straight from the flip-flops above.
    assign cpu_rdata_o       = rdata_q;
    assign cpu_rvalid_o      = rvalid_q;
    assign main_best_input_o = main_best_q;
    assign aux_best_input_o  = aux_best_q;
    assign main_prio_9_10_o  = main_9_10_q;
    assign main_prio_11_12_o = main_11_12_q;

endmodule

`default_nettype wire

// *** sim/irp_regs_chk.sv ***
// Checker for the input priority register bank.
`timescale 1ns/100ps
`default_nettype none
module irp_regs_chk (
    // Clock, reset and the two level inputs.
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic       master_slave_strap_i,
    input wire logic       path_bank_select_i,
    // Microprocessor port.
    input wire logic [6:0] cpu_addr_i,
    input wire logic       cpu_wr_i,
    input wire logic       cpu_rd_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic [7:0] cpu_rdata_o,
    input wire logic       cpu_rvalid_o,
    // Stored main path bytes and the main ranking result.
    input wire logic [7:0] main_prio_9_10_o,
    input wire logic [7:0] main_prio_11_12_o,
    input wire logic [3:0] main_best_input_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Main path write; a read in the same cycle is excluded from the read check since it sees old data.
    wire w0 = cpu_wr_i && !path_bank_select_i;
    wire z0 = main_prio_9_10_o == 8'h00 && main_prio_11_12_o == 8'h00;
    wire q0 = main_prio_9_10_o == 8'hff && main_prio_11_12_o == 8'h21;
    property p_w1; w0 && cpu_addr_i == 7'h1c |=> main_prio_9_10_o == $past(cpu_wdata_i); endproperty
    a_w1: assert property (p_w1) else $error("w1");
    property p_w2; w0 && cpu_addr_i == 7'h1d |=> main_prio_11_12_o == $past(cpu_wdata_i); endproperty
    a_w2: assert property (p_w2) else $error("w2");
    property p_aux; cpu_wr_i && path_bank_select_i |=> $stable(main_prio_11_12_o); endproperty
    a_aux: assert property (p_aux) else $error("aux");
    property p_rd; cpu_rd_i && !w0 && cpu_addr_i == 7'h1d && !path_bank_select_i
        |=> cpu_rvalid_o && cpu_rdata_o == $past(main_prio_11_12_o); endproperty
    a_rd: assert property (p_rd) else $error("rd");
    property p_r5; $fell(sys_rst_i) |-> main_prio_9_10_o == 8'hba; endproperty
    a_r5: assert property (p_r5) else $error("r5");
    property p_r6; $fell(sys_rst_i) |->
        main_prio_11_12_o == {4'hd, $past(master_slave_strap_i) ? 4'hc : 4'h1}; endproperty
    a_r6: assert property (p_r6) else $error("r6");
    property p_b3; z0 [*2] |-> main_best_input_o == 4'h0; endproperty
    a_b3: assert property (p_b3) else $error("b3");
    property p_b2; q0 [*2] |-> main_best_input_o == 4'hb; endproperty
    a_b2: assert property (p_b2) else $error("b2");
    c_rd: cover property (cpu_rd_i && path_bank_select_i);
    c_wr: cover property (w0);
    c_off: cover property (z0);
endmodule
bind irp_input_priority_regs irp_regs_chk u_chk (
    .clk_i                (clk_i),
    .sys_rst_i            (sys_rst_i),
    .master_slave_strap_i (master_slave_strap_i),
    .path_bank_select_i   (path_bank_select_i),
    .cpu_addr_i           (cpu_addr_i),
    .cpu_wr_i             (cpu_wr_i),
    .cpu_rd_i             (cpu_rd_i),
    .cpu_wdata_i          (cpu_wdata_i),
    .cpu_rdata_o          (cpu_rdata_o),
    .cpu_rvalid_o         (cpu_rvalid_o),
    .main_prio_9_10_o     (main_prio_9_10_o),
    .main_prio_11_12_o    (main_prio_11_12_o),
    .main_best_input_o    (main_best_input_o)
);
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the input priority register bank.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk_i = 1'h0, sys_rst_i = 1'h1, master_slave_strap_i = 1'h1, path_bank_select_i = 1'h0;
    logic       cpu_wr_i = 1'h0, cpu_rd_i = 1'h0;
    logic [6:0] cpu_addr_i = 7'h00;
    logic [7:0] cpu_wdata_i = 8'h00, cpu_rdata_o, main_prio_9_10_o, main_prio_11_12_o;
    logic [3:0] main_best_input_o, aux_best_input_o;
    logic       cpu_rvalid_o;
    int         fails = 0, samples_checked = 0;
    irp_input_priority_regs DUT (
        .clk_i                (clk_i),
        .sys_rst_i            (sys_rst_i),
        .master_slave_strap_i (master_slave_strap_i),
        .path_bank_select_i   (path_bank_select_i),
        .cpu_addr_i           (cpu_addr_i),
        .cpu_wr_i             (cpu_wr_i),
        .cpu_rd_i             (cpu_rd_i),
        .cpu_wdata_i          (cpu_wdata_i),
        .cpu_rdata_o          (cpu_rdata_o),
        .cpu_rvalid_o         (cpu_rvalid_o),
        .main_best_input_o    (main_best_input_o),
        .aux_best_input_o     (aux_best_input_o),
        .main_prio_9_10_o     (main_prio_9_10_o),
        .main_prio_11_12_o    (main_prio_11_12_o)
    );
    initial forever #25 clk_i = ~clk_i;
    // Counts a comparison and reports a mismatch at once.
    task automatic ck(string n, logic [7:0] e, logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    // One access; the valid pulse is checked on its own, high after a read and low after a write.
    task automatic acc(logic w, logic [6:0] a, logic b, logic [7:0] d);
        @(posedge clk_i);
        {cpu_wr_i, cpu_rd_i, cpu_addr_i, path_bank_select_i, cpu_wdata_i} <= {w, !w, a, b, d};
        @(posedge clk_i);
        {cpu_wr_i, cpu_rd_i} <= 2'h0;
        #1 if (!w) ck("read", d, cpu_rdata_o);
        ck("rvalid", {7'h00, !w}, {7'h00, cpu_rvalid_o});
    endtask
    // Ranked results lag the stored value by one cycle, so two edges are let pass.
    task automatic best(logic [3:0] m, logic [3:0] x);
        repeat (2) @(posedge clk_i);
        #1 ck("main_best", {4'h0, m}, {4'h0, main_best_input_o});
        ck("aux_best", {4'h0, x}, {4'h0, aux_best_input_o});
    endtask
    task automatic rst(logic s);
        @(posedge clk_i);
        {sys_rst_i, master_slave_strap_i} <= {1'b1, s};
        repeat (5) @(posedge clk_i);
        sys_rst_i <= 1'h0;
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // The tests take some 58 cycles; the watchdog allows far more.
    initial begin
        #50000 fails++;
        give_verdict;
    end
    initial begin
        rst(1'h1);
        acc(1'h0, 7'h1c, 1'h0, 8'hba);
        acc(1'h0, 7'h1c, 1'h1, 8'hba);
        acc(1'h0, 7'h1d, 1'h0, 8'hdc);
        acc(1'h0, 7'h1d, 1'h1, 8'h00);
        best(4'h9, 4'h9);
        $display("reset test done");
        acc(1'h1, 7'h1d, 1'h1, 8'h55);
        acc(1'h0, 7'h1d, 1'h0, 8'hdc);
        acc(1'h0, 7'h1d, 1'h1, 8'h55);
        acc(1'h1, 7'h1c, 1'h0, 8'hff);
        acc(1'h1, 7'h1d, 1'h0, 8'h21);
        acc(1'h1, 7'h1e, 1'h0, 8'h77);
        acc(1'h0, 7'h1e, 1'h0, 8'h00);
        ck("prio_9_10", 8'hff, main_prio_9_10_o);
        ck("prio_11_12", 8'h21, main_prio_11_12_o);
        best(4'hb, 4'hb);
        acc(1'h1, 7'h1c, 1'h0, 8'h00);
        acc(1'h1, 7'h1d, 1'h0, 8'h00);
        best(4'h0, 4'hb);
        acc(1'h1, 7'h1c, 1'h1, 8'h30);
        acc(1'h0, 7'h1c, 1'h0, 8'h00);
        acc(1'h0, 7'h1c, 1'h1, 8'h30);
        best(4'h0, 4'ha);
        $display("bank test done");
        rst(1'h0);
        acc(1'h0, 7'h1d, 1'h0, 8'hd1);
        acc(1'h0, 7'h1c, 1'h1, 8'hba);
        best(4'hb, 4'h9);
        $display("strap test done");
        give_verdict;
    end
endmodule
`default_nettype wire
